// file: wdp_pkg.sv
package wdp_pkg;

    // ==========================================================
    // Clock and tick timing
    localparam int CLK_PERIOD_PS      = 25000;
    localparam int REP_TICK_NS        = 10000;
    localparam int FIRST_TICK_NS      = 1000000;
    localparam int REP_TICK_CYC       = (REP_TICK_NS * 1000) / CLK_PERIOD_PS;
    localparam int FIRST_TICK_CYC     = (FIRST_TICK_NS / CLK_PERIOD_PS) * 1000;
    localparam int SHARE_LOST_CYC     = 2 * REP_TICK_CYC;
    localparam int REP_TICKS_PER_MS   = 1000000 / REP_TICK_NS;
    localparam int FIRST_TICKS_PER_MS = 1000000 / FIRST_TICK_NS;
    localparam int REP_MAX_US         = 600000;
    localparam int FIRST_MAX_MS       = 65000;
    localparam int REP_MAX_TICKS      = (REP_MAX_US * 1000) / REP_TICK_NS;
    localparam int FIRST_MAX_TICKS    = FIRST_MAX_MS * FIRST_TICKS_PER_MS;

    // ==========================================================
    // Command codes
    localparam logic [7:0] CMD_WD_FIRST  = 8'hE0;
    localparam logic [7:0] CMD_WD_REPEAT = 8'hE1;
    localparam logic [7:0] CMD_PAGE_MASK = 8'hE2;
    localparam logic [7:0] CMD_PADS      = 8'hE3;
    localparam logic [7:0] CMD_BASE_ADDR = 8'hE4;

    // ==========================================================
    // Reset values
    localparam logic [15:0] RST_WD_FIRST  = 16'h0000;
    localparam logic [15:0] RST_WD_REPEAT = 16'h0000;
    localparam logic [7:0]  RST_PAGE_MASK = 8'hFF;
    localparam logic [6:0]  RST_BASE_ADDR = 7'h40;

    // ==========================================================
    // Field layout
    localparam int L11_MANT_MSB     = 10;
    localparam int L11_EXP_LSB      = 11;
    localparam int BASE_ADDR_MSB    = 6;
    localparam int PAD_PG_BIT       = 15;
    localparam int PAD_ALERT_BIT    = 14;
    localparam int PAD_FDRV_LSB     = 10;
    localparam int PAD_ASEL_HI_LSB  = 8;
    localparam int PAD_ASEL_LO_LSB  = 6;
    localparam int PAD_CTRL_B_BIT   = 5;
    localparam int PAD_CTRL_A_BIT   = 4;
    localparam int PAD_FAULT_LSB    = 0;
    localparam logic [1:0] ASEL_HIGH  = 2'h3;
    localparam logic [1:0] ASEL_FLOAT = 2'h2;
    localparam logic [1:0] ASEL_LOW   = 2'h0;
    localparam logic [7:0] GLOBAL_PAGE = 8'hFF;
    localparam int NUM_CHAN         = 8;
    localparam logic [6:0] MAX_ADDR_OFS = 7'h09;

    // ==========================================================
    // Types
    typedef enum logic [4:0]
    {
        WD_OFF     = 5'h01,
        WD_WAIT_PG = 5'h02,
        WD_FIRST   = 5'h04,
        WD_REPEAT  = 5'h08,
        WD_HOLD    = 5'h10
    } wdp_wd_e;

    typedef struct packed
    {
        logic        wr;
        logic        rd;
        logic [6:0]  addr;
        logic [7:0]  code;
        logic [15:0] wdata;
        logic [7:0]  page;
    } wdp_cmd_s;

    typedef struct packed
    {
        logic [3:0] fault_bus_line_n;
        logic       run_control_a;
        logic       run_control_b;
        logic       addr_select_lo_high;
        logic       addr_select_lo_float;
        logic       addr_select_hi_high;
        logic       addr_select_hi_float;
        logic       watchdog_service_in;
        logic       share_clk;
    } wdp_pad_s;

    typedef struct packed
    {
        logic [15:0] first_reg;
        logic [15:0] rep_reg;
        logic [7:0]  mask;
        logic [6:0]  base;
        logic [15:0] first_ticks;
        logic [15:0] rep_ticks;
        wdp_wd_e     state;
        logic [15:0] tick_cnt;
        logic [15:0] pre_first;
        logic [15:0] pre_rep;
        logic [15:0] share_gap;
        logic        share_prev;
        logic        svc_prev;
        logic        alert;
        logic        pg_low;
        logic        expired;
        logic [23:0] hold_cnt;
        logic [6:0]  dev_addr;
        logic [7:0]  chan_en;
        logic [15:0] rd_data;
        logic        rd_valid;
    } wdp_regs_s;

endpackage

// file: wdp_sync.sv
`timescale 1ns/100ps
module wdp_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;

    // ==========================================================
    // Two-stage synchroniser
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            meta_ff  <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule

// file: wdp_l11_cnv.sv
`timescale 1ns/100ps
module wdp_l11_cnv #(
    parameter int TICKS_PER_MS = 1,
    parameter int MAX_TICKS    = 65000
) (
    input  wire logic [15:0] l11,
    output logic      [15:0] ticks
);
    logic [47:0] prod;
    logic [47:0] res;
    logic [4:0]  sh;

    // ==========================================================
    // Milliseconds in linear format to ticks, rounded to nearest
    always_comb
    begin
        prod = 48'(l11[wdp_pkg::L11_MANT_MSB-1:0]) * 48'(TICKS_PER_MS);
        sh   = 5'(~l11[15:wdp_pkg::L11_EXP_LSB] + 5'h01);
        if (!l11[15])
            res = prod << l11[15:wdp_pkg::L11_EXP_LSB];
        else
            res = (prod + (48'h1 << (sh - 5'h01))) >> sh;
        // Negative or zero mantissa leaves the timer disabled
        if (l11[wdp_pkg::L11_MANT_MSB] || l11[wdp_pkg::L11_MANT_MSB-1:0] == '0)
            res = '0;
        else if (res > 48'(MAX_TICKS))
            res = 48'(MAX_TICKS);
        else if (res == '0)
            res = 48'h1;
        ticks = res[15:0];
    end
endmodule

// file: wdp_regs.sv
// What this block does
// [RQ1] With power-good gated by watchdog, first interval starts at power-good assertion.
// [RQ2] Without gating, first interval starts when the watchdog becomes enabled.
// [RQ3] Zero mantissa in either interval register disables the watchdog.
// [RQ4] After the first interval, every interval uses the repeating value until a power-good wait or disable restarts the first.
// [RQ5] Write of the repeating interval with non-zero mantissa restarts the count.
// [RQ6] Both interval registers are 16-bit linear-format words in milliseconds.
// [RQ7] Intervals count on internal clock; repeating ticks follow the shared timebase while it runs.
// [RQ8] Repeating interval rounds to 10 us, first interval to 1 ms.
// [RQ9] Repeating interval capped at 0.6 s, first interval at 65 s.
// [RQ10] With page 0xFF only mask-enabled channels act on the access.
// [RQ11] Mask bit n enables channel n for global-page accesses.
// [RQ12] Pad status is read-only; bits 9:0 show pads before deglitching.
// [RQ13] Pad bit 15 reads 0 while power-good is pulled low.
// [RQ14] Pad bit 14 reads 0 while alert is pulled low.
// [RQ15] Pad bits 13:10 read 0 for fault-bus lines driven low.
// [RQ16] Address selects coded 11 high, 10 floating, 00 low.
// [RQ17] Pad bits 5 and 4 show the two run-control pad levels.
// [RQ18] Pad bits 3:0 show sensed fault-bus line levels.
// [RQ19] Base address keeps 7 bits; bit 7 reads zero.
// [RQ20] Device address is base plus offset 0 to 8; only it is answered.
// [RQ21] Rising edge on the service input restarts the watchdog.
// [RQ22] Expiry asserts alert; optionally drops power-good for the assertion delay.
// [RQ23] Offset comes from the two decoded three-level address selects.
`timescale 1ns/100ps
module wdp_regs #(
    parameter int FIRST_TICK_CYC = wdp_pkg::FIRST_TICK_CYC
) (
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire wdp_pkg::wdp_cmd_s cmd,
    input  wire wdp_pkg::wdp_pad_s pads,
    input  wire logic [3:0]        fault_drive_low,
    input  wire logic              pg_internal,
    input  wire logic              pg_follow_wd,
    input  wire logic              pg_drop_on_expiry,
    input  wire logic [23:0]       pg_delay_cycles,
    input  wire logic              alert_clear,
    output logic      [15:0]       rd_data_ff,
    output logic                   rd_valid_ff,
    output logic      [6:0]        dev_addr_ff,
    output logic      [7:0]        chan_en_ff,
    output logic                   alert_pull_low_ff,
    output logic                   pwrgd_pull_low_ff,
    output logic                   wd_expired_ff
);
    wdp_pkg::wdp_regs_s r_ff;
    wdp_pkg::wdp_regs_s nxt_r;
    wdp_pkg::wdp_pad_s  s;
    logic [15:0]        first_ticks_w;
    logic [15:0]        rep_ticks_w;
    logic               wr_w;
    logic               rd_w;
    logic               wd_en_w;
    logic               share_rise_w;
    logic               share_run_w;
    logic               tick_rep_w;
    logic               tick_first_w;
    logic               svc_rise_w;
    logic               restart_w;
    logic               expire_w;
    logic [1:0]         asel_lo_w;
    logic [1:0]         asel_hi_w;
    logic [6:0]         ofs_w;
    logic [15:0]        pad_w;

    // ==========================================================
    // Pad synchronisers and interval converters
    wdp_sync #(
        .WIDTH ($bits(wdp_pkg::wdp_pad_s))
    ) u_sync (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .async_in (pads),
        .sync_out (s)
    );

    wdp_l11_cnv #(
        .TICKS_PER_MS (wdp_pkg::FIRST_TICKS_PER_MS),
        .MAX_TICKS    (wdp_pkg::FIRST_MAX_TICKS)
    ) u_cnv_first (
        .l11   (r_ff.first_reg),
        .ticks (first_ticks_w)
    );

    wdp_l11_cnv #(
        .TICKS_PER_MS (wdp_pkg::REP_TICKS_PER_MS),
        .MAX_TICKS    (wdp_pkg::REP_MAX_TICKS)
    ) u_cnv_rep (
        .l11   (r_ff.rep_reg),
        .ticks (rep_ticks_w)
    );

    // ==========================================================
    // Decodes
    always_comb
    begin
        wr_w    = cmd.wr && cmd.addr == r_ff.dev_addr; // [RQ20]
        rd_w    = cmd.rd && cmd.addr == r_ff.dev_addr; // [RQ20]
        wd_en_w = r_ff.first_ticks != '0 && r_ff.rep_ticks != '0; // [RQ3]
        share_rise_w = s.share_clk && !r_ff.share_prev;
        share_run_w  = r_ff.share_gap < 16'(wdp_pkg::SHARE_LOST_CYC);
        // Repeating ticks lock to the shared timebase while it runs
        if (share_run_w)
            tick_rep_w = share_rise_w; // [RQ7]
        else
            tick_rep_w = r_ff.pre_rep == 16'(wdp_pkg::REP_TICK_CYC - 1); // [RQ7] [RQ8]
        tick_first_w = r_ff.pre_first == 16'(FIRST_TICK_CYC - 1); // [RQ8]
        svc_rise_w   = s.watchdog_service_in && !r_ff.svc_prev; // [RQ21]
        restart_w    = svc_rise_w
                       || (wr_w && cmd.code == wdp_pkg::CMD_WD_REPEAT
                           && cmd.wdata[wdp_pkg::L11_MANT_MSB:0] != '0); // [RQ5]
        expire_w = 1'b0;
        if (r_ff.state == wdp_pkg::WD_FIRST && tick_first_w
            && 16'(r_ff.tick_cnt + 16'h0001) >= r_ff.first_ticks)
            expire_w = wd_en_w && !restart_w;
        if (r_ff.state == wdp_pkg::WD_REPEAT && tick_rep_w
            && 16'(r_ff.tick_cnt + 16'h0001) >= r_ff.rep_ticks)
            expire_w = wd_en_w && !restart_w;
        asel_lo_w = s.addr_select_lo_high ? wdp_pkg::ASEL_HIGH
                  : (s.addr_select_lo_float ? wdp_pkg::ASEL_FLOAT : wdp_pkg::ASEL_LOW); // [RQ16]
        asel_hi_w = s.addr_select_hi_high ? wdp_pkg::ASEL_HIGH
                  : (s.addr_select_hi_float ? wdp_pkg::ASEL_FLOAT : wdp_pkg::ASEL_LOW); // [RQ16]
        // Offset is three times the upper select plus the lower, 0 to 8
        ofs_w = 7'(asel_hi_w[1] ? (asel_hi_w[0] ? 6 : 3) : 0)
              + 7'(asel_lo_w[1] ? (asel_lo_w[0] ? 2 : 1) : 0); // [RQ23]
        pad_w = '0;
        pad_w[wdp_pkg::PAD_PG_BIT]    = !r_ff.pg_low; // [RQ13]
        pad_w[wdp_pkg::PAD_ALERT_BIT] = !r_ff.alert; // [RQ14]
        pad_w[wdp_pkg::PAD_FDRV_LSB +: 4]    = ~fault_drive_low; // [RQ15]
        pad_w[wdp_pkg::PAD_ASEL_HI_LSB +: 2] = asel_hi_w; // [RQ16]
        pad_w[wdp_pkg::PAD_ASEL_LO_LSB +: 2] = asel_lo_w; // [RQ16]
        pad_w[wdp_pkg::PAD_CTRL_B_BIT] = s.run_control_b; // [RQ17]
        pad_w[wdp_pkg::PAD_CTRL_A_BIT] = s.run_control_a; // [RQ17]
        pad_w[wdp_pkg::PAD_FAULT_LSB +: 4] = s.fault_bus_line_n; // [RQ12] [RQ18]
    end

    // ==========================================================
    // Next state
    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.rd_valid = rd_w;
        nxt_r.expired  = expire_w;
        if (wr_w)
        begin
            case (cmd.code)
                wdp_pkg::CMD_WD_FIRST:  nxt_r.first_reg = cmd.wdata; // [RQ6]
                wdp_pkg::CMD_WD_REPEAT: nxt_r.rep_reg   = cmd.wdata; // [RQ6]
                wdp_pkg::CMD_PAGE_MASK: nxt_r.mask      = cmd.wdata[7:0]; // [RQ11]
                wdp_pkg::CMD_BASE_ADDR: nxt_r.base      = cmd.wdata[wdp_pkg::BASE_ADDR_MSB:0]; // [RQ19]
                default:                nxt_r.mask      = r_ff.mask; // [RQ12]
            endcase
        end
        if (rd_w)
        begin
            case (cmd.code)
                wdp_pkg::CMD_WD_FIRST:  nxt_r.rd_data = r_ff.first_reg;
                wdp_pkg::CMD_WD_REPEAT: nxt_r.rd_data = r_ff.rep_reg;
                wdp_pkg::CMD_PAGE_MASK: nxt_r.rd_data = {8'h00, r_ff.mask};
                wdp_pkg::CMD_PADS:      nxt_r.rd_data = pad_w; // [RQ12]
                wdp_pkg::CMD_BASE_ADDR: nxt_r.rd_data = {9'h000, r_ff.base}; // [RQ19]
                default:                nxt_r.rd_data = 16'h0000;
            endcase
        end
        nxt_r.first_ticks = first_ticks_w; // [RQ8] [RQ9]
        nxt_r.rep_ticks   = rep_ticks_w; // [RQ8] [RQ9]
        nxt_r.share_prev  = s.share_clk;
        nxt_r.svc_prev    = s.watchdog_service_in;
        if (share_rise_w)
            nxt_r.share_gap = '0;
        else if (share_run_w)
            nxt_r.share_gap = 16'(r_ff.share_gap + 16'h0001);
        // Restart or expiry opens a full interval, not a partial first tick
        if (tick_rep_w || restart_w || expire_w)
            nxt_r.pre_rep = '0; // [RQ5] [RQ4]
        else
            nxt_r.pre_rep = 16'(r_ff.pre_rep + 16'h0001);
        nxt_r.pre_first = tick_first_w ? 16'h0000 : 16'(r_ff.pre_first + 16'h0001);
        nxt_r.dev_addr  = 7'(r_ff.base + ofs_w); // [RQ20]
        if (cmd.page == wdp_pkg::GLOBAL_PAGE)
            nxt_r.chan_en = r_ff.mask; // [RQ10] [RQ11]
        else if (cmd.page < 8'(wdp_pkg::NUM_CHAN))
            nxt_r.chan_en = 8'h01 << cmd.page[2:0];
        else
            nxt_r.chan_en = 8'h00;
        // A new expiry wins over a clear in the same cycle
        nxt_r.alert = (r_ff.alert && !alert_clear) || expire_w; // [RQ22]

        case (r_ff.state)
            wdp_pkg::WD_OFF:
            begin
                nxt_r.tick_cnt  = '0;
                nxt_r.pre_first = '0;
                if (wd_en_w)
                    nxt_r.state = pg_follow_wd ? wdp_pkg::WD_WAIT_PG : wdp_pkg::WD_FIRST; // [RQ2]
            end
            wdp_pkg::WD_WAIT_PG:
            begin
                nxt_r.tick_cnt  = '0;
                nxt_r.pre_first = '0;
                if (!r_ff.pg_low)
                    nxt_r.state = wdp_pkg::WD_FIRST; // [RQ1]
            end
            wdp_pkg::WD_FIRST:
            begin
                if (tick_first_w)
                    nxt_r.tick_cnt = 16'(r_ff.tick_cnt + 16'h0001); // [RQ7]
                if (restart_w)
                begin
                    nxt_r.state    = wdp_pkg::WD_REPEAT; // [RQ21]
                    nxt_r.tick_cnt = '0;
                end
            end
            wdp_pkg::WD_REPEAT:
            begin
                if (tick_rep_w)
                    nxt_r.tick_cnt = 16'(r_ff.tick_cnt + 16'h0001); // [RQ7]
                if (restart_w)
                    nxt_r.tick_cnt = '0; // [RQ5] [RQ21]
            end
            wdp_pkg::WD_HOLD:
            begin
                nxt_r.tick_cnt = '0;
                nxt_r.hold_cnt = 24'(r_ff.hold_cnt + 24'h000001);
                if (r_ff.hold_cnt >= pg_delay_cycles)
                    nxt_r.state = pg_follow_wd ? wdp_pkg::WD_WAIT_PG : wdp_pkg::WD_REPEAT; // [RQ22]
            end
            default:
                nxt_r.state = wdp_pkg::WD_OFF;
        endcase

        if (expire_w)
        begin
            nxt_r.tick_cnt = '0;
            nxt_r.hold_cnt = '0;
            nxt_r.state    = pg_drop_on_expiry ? wdp_pkg::WD_HOLD : wdp_pkg::WD_REPEAT; // [RQ4] [RQ22]
        end
        if (pg_follow_wd && r_ff.pg_low
            && (r_ff.state == wdp_pkg::WD_FIRST || r_ff.state == wdp_pkg::WD_REPEAT))
            nxt_r.state = wdp_pkg::WD_WAIT_PG; // [RQ1]
        if (!wd_en_w)
            nxt_r.state = wdp_pkg::WD_OFF; // [RQ3]
        nxt_r.pg_low = !pg_internal || nxt_r.state == wdp_pkg::WD_HOLD; // [RQ22]
    end

    // ==========================================================
    // State register
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            r_ff           <= '0;
            r_ff.first_reg <= wdp_pkg::RST_WD_FIRST;
            r_ff.rep_reg   <= wdp_pkg::RST_WD_REPEAT;
            r_ff.mask      <= wdp_pkg::RST_PAGE_MASK;
            r_ff.base      <= wdp_pkg::RST_BASE_ADDR;
            r_ff.state     <= wdp_pkg::WD_OFF;
            r_ff.share_gap <= 16'(wdp_pkg::SHARE_LOST_CYC);
            r_ff.pg_low    <= 1'b1;
            r_ff.dev_addr  <= wdp_pkg::RST_BASE_ADDR;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    assign rd_data_ff        = r_ff.rd_data;
    assign rd_valid_ff       = r_ff.rd_valid;
    assign dev_addr_ff       = r_ff.dev_addr;
    assign chan_en_ff        = r_ff.chan_en;
    assign alert_pull_low_ff = r_ff.alert;
    assign pwrgd_pull_low_ff = r_ff.pg_low;
    assign wd_expired_ff     = r_ff.expired;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_expiry;
        expire_w ##1 (alert_pull_low_ff && wd_expired_ff);
    endsequence
    sequence s_pads_read;
        rd_w && cmd.code == wdp_pkg::CMD_PADS;
    endsequence

    property p_zero_disable;
        (r_ff.first_ticks == '0 || r_ff.rep_ticks == '0) |=> r_ff.state == wdp_pkg::WD_OFF;
    endproperty
    a_zero_disable: assert property (p_zero_disable) else $error("watchdog runs with zero interval"); // [RQ3]

    property p_rep_restart;
        (restart_w && wd_en_w && r_ff.state == wdp_pkg::WD_REPEAT && !(pg_follow_wd && r_ff.pg_low))
        |=> (r_ff.tick_cnt == '0 && r_ff.state == wdp_pkg::WD_REPEAT);
    endproperty
    a_rep_restart: assert property (p_rep_restart) else $error("restart did not clear count"); // [RQ5]

    property p_svc_first;
        (svc_rise_w && wd_en_w && r_ff.state == wdp_pkg::WD_FIRST && !(pg_follow_wd && r_ff.pg_low))
        |=> r_ff.state == wdp_pkg::WD_REPEAT;
    endproperty
    a_svc_first: assert property (p_svc_first) else $error("service edge ignored in first interval"); // [RQ21]

    property p_first_start;
        (r_ff.state == wdp_pkg::WD_WAIT_PG && !r_ff.pg_low && wd_en_w)
        |=> (r_ff.state == wdp_pkg::WD_FIRST && r_ff.tick_cnt == '0);
    endproperty
    a_first_start: assert property (p_first_start) else $error("first interval not started"); // [RQ1]

    property p_first_to_rep;
        (expire_w && r_ff.state == wdp_pkg::WD_FIRST && !pg_drop_on_expiry && wd_en_w
         && !(pg_follow_wd && r_ff.pg_low)) |=> r_ff.state == wdp_pkg::WD_REPEAT;
    endproperty
    a_first_to_rep: assert property (p_first_to_rep) else $error("no repeat phase after first"); // [RQ4]

    property p_expiry_alert;
        expire_w |-> s_expiry;
    endproperty
    a_expiry_alert: assert property (p_expiry_alert) else $error("expiry without alert"); // [RQ22]

    property p_pad_pg;
        s_pads_read |=> (rd_valid_ff && rd_data_ff[wdp_pkg::PAD_PG_BIT] == !$past(r_ff.pg_low)
                         && rd_data_ff[wdp_pkg::PAD_ALERT_BIT] == !$past(r_ff.alert));
    endproperty
    a_pad_pg: assert property (p_pad_pg) else $error("pad drive bits wrong"); // [RQ13]

    property p_base_bit7;
        (rd_w && cmd.code == wdp_pkg::CMD_BASE_ADDR) |=> rd_data_ff[15:7] == '0;
    endproperty
    a_base_bit7: assert property (p_base_bit7) else $error("base address upper bits set"); // [RQ19]

    property p_global_mask;
        cmd.page == wdp_pkg::GLOBAL_PAGE |=> chan_en_ff == $past(r_ff.mask);
    endproperty
    a_global_mask: assert property (p_global_mask) else $error("global page ignores mask"); // [RQ10]

    property p_addr_range;
        ##1 7'(dev_addr_ff - $past(r_ff.base)) <= wdp_pkg::MAX_ADDR_OFS;
    endproperty
    a_addr_range: assert property (p_addr_range) else $error("address offset out of range"); // [RQ20]

    property p_limits;
        r_ff.rep_ticks <= 16'(wdp_pkg::REP_MAX_TICKS) && r_ff.first_ticks <= 16'(wdp_pkg::FIRST_MAX_TICKS);
    endproperty
    a_limits: assert property (p_limits) else $error("interval above limit"); // [RQ9]

    property p_share_align;
        (share_run_w && tick_rep_w) |-> share_rise_w;
    endproperty
    a_share_align: assert property (p_share_align) else $error("tick off shared timebase"); // [RQ7]
endmodule

// file: wdp_proc_model.sv
`timescale 1ns/100ps
module wdp_proc_model (
    input  wire logic core_clk,
    input  wire logic kick,
    output logic      service_out,
    output logic      share_out
);
    // ==========================================================
    // Service edge on request; shared timebase held idle
    initial service_out = 1'b0;
    assign share_out = 1'b0;
    always @(posedge core_clk)
    begin
        if (kick)
        begin
            service_out <= 1'b1;
            repeat (8) @(posedge core_clk);
            service_out <= 1'b0;
        end
    end
endmodule

// file: wdp_regs_test.sv
`timescale 1ns/100ps
module wdp_regs_test;
    logic              core_clk = 1'b0;
    logic              reset_n  = 1'b0;
    wdp_pkg::wdp_cmd_s cmd      = '0;
    wdp_pkg::wdp_pad_s pads     = '0;
    logic              kick     = 1'b0;
    logic              alert_clear = 1'b0;
    logic              pg_ok       = 1'b1;
    logic              svc_w;
    logic              share_w;
    wdp_pkg::wdp_pad_s pad_bus;
    logic [15:0]       rd_data_ff;
    logic              rd_valid_ff, alert_pull_low_ff, pwrgd_pull_low_ff, wd_expired_ff;
    logic [6:0]        dev_addr_ff;
    logic [7:0]        chan_en_ff;
    int                fail_count  = 0;
    int                comparisons = 0;
    int                n;
    int                hits;

    always #12.5 core_clk = ~core_clk;

    // Model outputs join the bench-driven pad levels
    always_comb
    begin
        pad_bus                     = pads;
        pad_bus.watchdog_service_in = svc_w;
        pad_bus.share_clk           = share_w;
    end

    wdp_proc_model u_proc (.core_clk(core_clk), .kick(kick), .service_out(svc_w),
                           .share_out(share_w));
    wdp_regs #(.FIRST_TICK_CYC(40)) u_dut (.core_clk(core_clk), .reset_n(reset_n), .cmd(cmd), .pads(pad_bus),
        .fault_drive_low(4'h5), .pg_internal(pg_ok), .pg_follow_wd(1'b0), .pg_drop_on_expiry(1'b0),
        .pg_delay_cycles(24'h000000), .alert_clear(alert_clear), .rd_data_ff(rd_data_ff),
        .rd_valid_ff(rd_valid_ff), .dev_addr_ff(dev_addr_ff), .chan_en_ff(chan_en_ff),
        .alert_pull_low_ff(alert_pull_low_ff), .pwrgd_pull_low_ff(pwrgd_pull_low_ff),
        .wd_expired_ff(wd_expired_ff));

    // ==========================================================
    // Access tasks
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
            fail_count++;
        end
    endtask

    task automatic wr(input logic [7:0] cd, input logic [15:0] d);
        @(negedge core_clk);
        cmd.wr = 1'b1;
        cmd.code = cd;
        cmd.wdata = d;
        @(negedge core_clk);
        cmd.wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] cd, input logic [15:0] e, input logic v);
        logic got;
        got = 1'b0;
        @(negedge core_clk);
        cmd.rd = 1'b1;
        cmd.code = cd;
        for (int i = 0; i < 3; i++)
        begin
            @(negedge core_clk);
            cmd.rd = 1'b0;
            if (rd_valid_ff === 1'b1 && !got)
            begin
                got = 1'b1;
                chk($sformatf("read %h", cd), rd_data_ff, e);
            end
        end
        chk("rd_valid", 16'(got), 16'(v));
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wait_exp();
        n = 0;
        while (wd_expired_ff !== 1'b1 && n < 30000)
        begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 30000)
        begin
            fail_count++;
            results();
        end
        @(negedge core_clk);
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        cmd.addr = 7'h47;
        pads.fault_bus_line_n = 4'hA;
        pads.run_control_a = 1'b1;
        pads.addr_select_lo_float = 1'b1;
        pads.addr_select_hi_high = 1'b1;
        repeat (20) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (8) @(negedge core_clk);
        chk("dev_addr", 16'(dev_addr_ff), 16'h0047);
        rd(8'hE0, 16'h0000, 1'b1);
        rd(8'hE2, 16'h00FF, 1'b1);
        rd(8'hE3, 16'hEB9A, 1'b1);
        pg_ok = 1'b0;
        wr(8'hE3, 16'h0000);
        chk("pwrgd", 16'(pwrgd_pull_low_ff), 16'h0001);
        rd(8'hE3, 16'h6B9A, 1'b1);
        pg_ok = 1'b1;
        wr(8'hE4, 16'h00A2);
        rd(8'hE4, 16'h0000, 1'b0);
        cmd.addr = 7'h29;
        rd(8'hE4, 16'h0022, 1'b1);
        wr(8'hE2, 16'h005A);
        cmd.page = 8'hFF;
        repeat (2) @(negedge core_clk);
        chk("chan_en", 16'(chan_en_ff), 16'h005A);
        cmd.page = 8'h03;
        repeat (2) @(negedge core_clk);
        chk("chan_en", 16'(chan_en_ff), 16'h0008);
        wr(8'hE1, 16'hF801);
        wr(8'hE0, 16'h0001);
        wait_exp();
        chk("first", 16'(n < 60), 16'h0001);
        chk("alert", 16'(alert_pull_low_ff), 16'h0001);
        alert_clear = 1'b1;
        @(negedge core_clk);
        alert_clear = 1'b0;
        @(negedge core_clk);
        chk("alert", 16'(alert_pull_low_ff), 16'h0000);
        repeat (10000) @(negedge core_clk);
        wr(8'hE1, 16'hF801);
        wait_exp();
        chk("restart", 16'(n > 19990 && n < 20010), 16'h0001);
        repeat (10000) @(negedge core_clk);
        kick = 1'b1;
        @(negedge core_clk);
        kick = 1'b0;
        wait_exp();
        chk("service", 16'(n > 19990 && n < 20010), 16'h0001);
        wr(8'hE0, 16'h0000);
        hits = 0;
        repeat (25000)
        begin
            @(negedge core_clk);
            hits += int'(wd_expired_ff === 1'b1);
        end
        chk("disabled", 16'(hits), 16'h0000);
        results();
    end
endmodule
